// ==== src/lars_regs.svh ====
// Constants for the linear array readout sequencer
`ifndef LARS_REGS_SVH
`define LARS_REGS_SVH
`define LARS_PIXEL_COUNT 128
`define LARS_CNT_W 8
`define LARS_TINT_MAX_MS 100
`define LARS_ARRAY_CLK_MAX_KHZ 5000
`define LARS_REF_CLK_KHZ 40000
`define LARS_ARRAY_CLK_MIN_NS 200
`define LARS_REF_CLK_NS 25
`define LARS_ARRAY_CLK_MIN_CYC ((`LARS_ARRAY_CLK_MIN_NS + `LARS_REF_CLK_NS - 1) / `LARS_REF_CLK_NS)
`define LARS_TINT_MAX_CYC (`LARS_TINT_MAX_MS * `LARS_REF_CLK_KHZ)
`define LARS_PIX_RESET 8'h00
`endif

// ==== src/lars_pkg.sv ====
// Types for the linear array readout sequencer
package lars_pkg;
  typedef enum logic [1:0] {
    LARS_IDLE = 2'b00,
    LARS_READ = 2'b01,
    LARS_LAST = 2'b10
  } lars_state_type;
endpackage

// ==== src/lars_edge_detect.sv ====
// Rising-edge detector for array clock and start inputs
`timescale 1ns/10ps
module lars_edge_detect (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Level in, pulse out
  input wire logic level_in,
  output logic rise_pulse
);
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = level_in;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign rise_pulse = level_in & ~prev_r;
endmodule

// ==== src/lars_sequencer.sv ====
// Device-side readout sequencer for a serially clocked linear photodiode array
`timescale 1ns/10ps
`include "lars_regs.svh"
module lars_sequencer #(
  parameter int PIXEL_COUNT = `LARS_PIXEL_COUNT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Array pins from the controller
  input wire logic array_clk,
  input wire logic start_in,
  // Analog stand-in: index of pixel on output, and its enable
  output logic [`LARS_CNT_W-1:0] pixel_index,
  output logic out_valid,
  output logic out_oe_n,
  // Per-pixel switch controls for the selected pixel
  output logic integrator_reset_switch,
  output logic sample_hold_switch,
  // Serial output toward a cascaded section
  output logic serial_out
);
  lars_pkg::lars_state_type state_r;
  lars_pkg::lars_state_type state_nxt;
  logic [`LARS_CNT_W-1:0] pix_r;
  logic [`LARS_CNT_W-1:0] pix_nxt;
  logic rst_sw_r;
  logic rst_sw_nxt;
  logic hold_r;
  logic hold_nxt;
  logic valid_r;
  logic valid_nxt;
  logic so_r;
  logic so_nxt;
  logic start_armed_r;
  logic start_armed_nxt;
  logic clk_rise;
  logic start_rise;
  logic start_take;
  logic in_read;
  logic at_last;
  logic advance;
  logic finish;

  lars_edge_detect u_clk_edge (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .level_in(array_clk),
    .rise_pulse(clk_rise)
  );

  lars_edge_detect u_start_edge (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .level_in(start_in),
    .rise_pulse(start_rise)
  );

  // Index of the pixel that follows p
  function automatic logic [`LARS_CNT_W-1:0] next_pix(input logic [`LARS_CNT_W-1:0] p);
    next_pix = p + `LARS_CNT_W'(1);
  endfunction

  // True when p is the final pixel of the chain
  function automatic logic is_last_pix(input logic [`LARS_CNT_W-1:0] p);
    is_last_pix = (p == `LARS_CNT_W'(PIXEL_COUNT - 1));
  endfunction

  // Events decoded from one array clock rise
  always_comb begin
    in_read = (state_r == lars_pkg::LARS_READ);
    at_last = is_last_pix(pix_r);
    start_take = clk_rise & (start_armed_r | start_rise);
    advance = clk_rise & ~start_take & in_read & ~at_last;
    finish = clk_rise & ~start_take & in_read & at_last;
  end

  // Start is a rising transition held until the next array clock rise
  always_comb begin
    start_armed_nxt = start_armed_r;
    if (clk_rise) begin
      start_armed_nxt = 1'b0;
    end else if (start_rise) begin
      start_armed_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      start_armed_r <= 1'b0;
    end else begin
      start_armed_r <= start_armed_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    if (start_take) begin
      state_nxt = lars_pkg::LARS_READ;
    end else if (clk_rise) begin
      case (state_r)
        lars_pkg::LARS_READ: begin
          if (at_last) begin
            state_nxt = lars_pkg::LARS_LAST;
          end
        end
        lars_pkg::LARS_LAST: begin
          state_nxt = lars_pkg::LARS_IDLE;
        end
        lars_pkg::LARS_IDLE: begin
          state_nxt = lars_pkg::LARS_IDLE;
        end
        default: begin
          state_nxt = lars_pkg::LARS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= lars_pkg::LARS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pixel pointer: restart on start, one step per period while reading, holding at the last pixel
  always_comb begin
    pix_nxt = pix_r;
    if (start_take) begin
      pix_nxt = `LARS_PIX_RESET;
    end else if (advance) begin
      pix_nxt = next_pix(pix_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pix_r <= `LARS_PIX_RESET;
    end else begin
      pix_r <= pix_nxt;
    end
  end

  // Hold and clear for the selected pixel; released when no pixel is selected
  always_comb begin
    rst_sw_nxt = rst_sw_r;
    hold_nxt = hold_r;
    if (clk_rise) begin
      rst_sw_nxt = start_take | advance;
      hold_nxt = start_take | advance;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rst_sw_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      rst_sw_r <= rst_sw_nxt;
      hold_r <= hold_nxt;
    end
  end

  always_comb begin
    valid_nxt = valid_r;
    if (start_take) begin
      valid_nxt = 1'b1;
    end else if (clk_rise && (!in_read || at_last)) begin
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // End-of-data flag for a cascaded section, until the next rise
  always_comb begin
    so_nxt = so_r;
    if (finish) begin
      so_nxt = 1'b1;
    end else if (clk_rise) begin
      so_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      so_r <= 1'b0;
    end else begin
      so_r <= so_nxt;
    end
  end

  // Output held for the whole array clock period
  assign pixel_index = pix_r;
  assign out_valid = valid_r;
  assign out_oe_n = ~valid_r;
  assign integrator_reset_switch = rst_sw_r;
  assign sample_hold_switch = hold_r;
  assign serial_out = so_r;
endmodule

// ==== tb/lars_sequencer_sva.sv ====
// Checker for the readout sequencer ports
`timescale 1ns/10ps
module lars_sequencer_sva #(
  parameter int PIXEL_COUNT = 128
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Array pins
  input wire logic array_clk,
  input wire logic start_in,
  // Outputs watched
  input wire logic [7:0] pixel_index,
  input wire logic out_valid,
  input wire logic out_oe_n,
  input wire logic integrator_reset_switch,
  input wire logic sample_hold_switch,
  input wire logic serial_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_start_first: assert property ($rose(array_clk) && start_in |=>
    pixel_index == 8'h00 && out_valid && integrator_reset_switch && sample_hold_switch) else $error("no first pixel");
  chk_pixel_step: assert property ($rose(array_clk) && !start_in && out_valid && pixel_index < PIXEL_COUNT - 1
    |=> out_valid && pixel_index == $past(pixel_index) + 1) else $error("pixel not advanced");
  chk_period_hold: assert property (out_valid && !$rose(array_clk) |=> $stable(pixel_index) && out_valid)
    else $error("pixel not held");
  chk_hiz_last: assert property ($rose(array_clk) && !start_in && out_valid && pixel_index == PIXEL_COUNT - 1
    |=> out_oe_n && !out_valid && serial_out) else $error("no high impedance");
  chk_switch_on: assert property (out_valid |-> integrator_reset_switch && sample_hold_switch && !out_oe_n)
    else $error("switches off");
  chk_serial_drop: assert property (serial_out && $rose(array_clk) |=> !serial_out) else $error("serial stuck");
  chk_idle_quiet: assert property (!out_valid && $rose(array_clk) && !start_in |=> !out_valid)
    else $error("output without start");
endmodule
bind lars_sequencer lars_sequencer_sva #(.PIXEL_COUNT(PIXEL_COUNT)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .array_clk(array_clk), .start_in(start_in), .pixel_index(pixel_index), .out_valid(out_valid),
  .out_oe_n(out_oe_n), .integrator_reset_switch(integrator_reset_switch),
  .sample_hold_switch(sample_hold_switch), .serial_out(serial_out));

// ==== tb/lars_ctrl_model.sv ====
// Controller model: start pulse and array clock bursts
`timescale 1ns/10ps
module lars_ctrl_model #(
  parameter int HALF = 4
) (
  // Clock and request
  input wire logic ref_clk,
  input wire logic go,
  input wire logic with_start,
  input wire logic [8:0] n_clk,
  // Array pins
  output logic array_clk,
  output logic start_in,
  output logic busy
);
  int ph;
  int left;
  initial begin
    array_clk = 1'b0;
    start_in = 1'b0;
    busy = 1'b0;
  end
  // Clock low while idle; 8 ref cycles per period
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left <= n_clk;
      ph <= 0;
      start_in <= with_start;
    end else if (busy) begin
      ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) array_clk <= 1'b1;
      if (ph == HALF) start_in <= 1'b0;
      if (ph == 2 * HALF - 1) begin
        array_clk <= 1'b0;
        left <= left - 1;
        if (left == 1) busy <= 1'b0;
      end
    end
  end
endmodule

// ==== tb/lars_sequencer_bench.sv ====
// Self-checking bench for the readout sequencer
`timescale 1ns/10ps
module lars_sequencer_bench;
  localparam int PC = 4;
  logic ref_clk = 1'b0, reset_n = 1'b0, go = 1'b0, ws = 1'b0, array_clk, start_in, busy;
  logic [8:0] n_clk = 9'h000;
  logic [7:0] pixel_index;
  logic out_valid, out_oe_n, irs, shs, serial_out;
  int fail_count = 0, total_checks = 0;
  lars_ctrl_model ctrl (.ref_clk(ref_clk), .go(go), .with_start(ws), .n_clk(n_clk), .array_clk(array_clk),
    .start_in(start_in), .busy(busy));
  lars_sequencer #(.PIXEL_COUNT(PC)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .array_clk(array_clk),
    .start_in(start_in), .pixel_index(pixel_index), .out_valid(out_valid), .out_oe_n(out_oe_n),
    .integrator_reset_switch(irs), .sample_hold_switch(shs), .serial_out(serial_out));
  initial forever #12.5 ref_clk = ~ref_clk;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One burst of n array clocks, judged in the middle of each period
  task frame(input logic s, input int n);
    logic v;
    ws <= s;
    n_clk <= 9'(n);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge array_clk);
      @(negedge ref_clk);
      v = s && i < PC;
      check({7'h00, out_oe_n}, {7'h00, !v});
      check({7'h00, out_valid}, {7'h00, v});
      check({6'h00, irs, shs}, v ? 8'h03 : 8'h00);
      if (v) check(pixel_index, 8'(i));
      check({7'h00, serial_out}, {7'h00, s && i == PC});
    end
    repeat (12) @(posedge ref_clk);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check({out_valid, out_oe_n, pixel_index[5:0]}, 8'h40);
    frame(1'b1, PC + 1);
    frame(1'b0, 3);
    frame(1'b1, PC);
    frame(1'b1, PC + 1);
    frame(1'b1, 2);
    frame(1'b1, PC + 1);
    end_of_test();
  end
  initial begin
    #200us;
    fail_count++;
    end_of_test();
  end
endmodule
